// File: logic/out_clock_sync.v
`timescale 1ns/100ps
// Summary of operation
// - sync reset only under extended control, off by default
// - i and q clocks always share one phase
// - sync reset accepted asynchronously to sample clock
// - demux: clock held high; non-demux: keeps toggling
// - a narrow pulse may appear at assertion
// - sync edge 4 cycles (90 deg) or 5 (0 deg)
// - clock re-enabled after fixed output delay
// - first pulse undefined; later pulses defined; send dummy
// - slave follows master phase, recovers next cycle
// - slave picks one of four phases from reference
// - tree: following for slaves, sync reset for masters
// - clock from sample clock; in demux mode shifted by aperture adjust
`include "out_clock_sync_regs.vh"
module out_clock_sync (
    input wire clk_in,
    input wire rst_n_in,
    input wire extended_control_mode_in,
    input wire sync_reset_enable_in,
    input wire demux_mode_in,
    input wire output_clock_phase_select_in,
    input wire slave_mode_in,
    input wire [1:0] aperture_delay_adjust_in,
    input wire out_clock_sync_reset_in,
    input wire sync_ref_clock_in,
    output reg i_channel_output_clock_out,
    output reg q_channel_output_clock_out,
    output reg sync_ref_clock_out_a_out,
    output reg sync_ref_clock_out_b_out,
    output wire sync_reset_active_out,
    output reg sync_done_out
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg rst_meta_r, rst_sync_r, ref_meta_r, ref_sync_r, ref_prev_r;
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
            ref_meta_r <= 1'b0;
            ref_sync_r <= 1'b0;
            ref_prev_r <= 1'b0;
        end else begin
            rst_meta_r <= out_clock_sync_reset_in;
            rst_sync_r <= rst_meta_r;
            ref_meta_r <= sync_ref_clock_in;
            ref_sync_r <= ref_meta_r;
            ref_prev_r <= ref_sync_r;
        end
    end
    // gate only the synchronised copy; reset path is off until software enables it
    wire sync_en = extended_control_mode_in & sync_reset_enable_in;
    wire hold = sync_en & rst_sync_r;
    assign sync_reset_active_out = hold;
    // ----------------------------------------
    // phase counter and release sequencer
    // ----------------------------------------
    localparam ST_RUN = 2'h0;
    localparam ST_HOLD = 2'h1;
    localparam ST_DLY = 2'h2;
    localparam ST_OUT = 2'h3;
    reg [1:0] state_r, state_nxt;
    reg [2:0] cnt_r, cnt_nxt;
    reg [`PHASE_W-1:0] phase_r, phase_nxt;
    reg seen_pulse_r, seen_pulse_nxt;
    wire ref_rise = ref_sync_r & ~ref_prev_r;
    wire [2:0] sync_dly = output_clock_phase_select_in ? `SYNC_DLY_90_CYC : `SYNC_DLY_0_CYC;
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        phase_nxt = phase_r + 2'h1;
        seen_pulse_nxt = seen_pulse_r;
        if (slave_mode_in && ref_rise) begin
            phase_nxt = 2'h1;
        end
        case (state_r)
            ST_RUN: begin
                if (hold) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                cnt_nxt = 3'h1;
                if (!hold) begin
                    state_nxt = ST_DLY;
                end
            end
            ST_DLY: begin
                cnt_nxt = cnt_r + 3'h1;
                if (cnt_r == sync_dly) begin
                    // first pulse after power-up leaves phase unaligned
                    if (seen_pulse_r) begin
                        phase_nxt = 2'h0;
                    end
                    seen_pulse_nxt = 1'b1;
                    cnt_nxt = 3'h1;
                    state_nxt = ST_OUT;
                end
            end
            ST_OUT: begin
                cnt_nxt = cnt_r + 3'h1;
                if (cnt_r == `OUT_DELAY_CYC) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
        if (hold) begin
            state_nxt = ST_HOLD;
        end
    end
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= ST_RUN;
            cnt_r <= 3'h0;
            phase_r <= 2'h0;
            seen_pulse_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            phase_r <= phase_nxt;
            seen_pulse_r <= seen_pulse_nxt;
        end
    end
    // ----------------------------------------
    // output clock generation
    // ----------------------------------------
    // aperture adjust shifts the edge to cancel board clock skew
    wire [1:0] shifted = phase_r - aperture_delay_adjust_in;
    // hold is looked at directly so the clock parks high one cycle sooner
    wire gated = demux_mode_in && (hold || (state_r != ST_RUN));
    wire output_data_clock_nxt = gated ? 1'b1 :
        (demux_mode_in ? ~shifted[1] : ~(i_channel_output_clock_out));
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            i_channel_output_clock_out <= 1'b0;
            q_channel_output_clock_out <= 1'b0;
            sync_ref_clock_out_a_out <= 1'b0;
            sync_ref_clock_out_b_out <= 1'b0;
            sync_done_out <= 1'b0;
        end else begin
            i_channel_output_clock_out <= output_data_clock_nxt;
            q_channel_output_clock_out <= output_data_clock_nxt;
            sync_ref_clock_out_a_out <= (phase_r == 2'h0);
            sync_ref_clock_out_b_out <= (phase_r == 2'h0);
            sync_done_out <= (state_r == ST_OUT) && (cnt_r == `OUT_DELAY_CYC);
        end
    end
endmodule

// File: logic/out_clock_sync_regs.vh
`ifndef OUT_CLOCK_SYNC_REGS_VH
`define OUT_CLOCK_SYNC_REGS_VH
// ----------------------------------------
// timing counts, in sampling clock cycles
// ----------------------------------------
`define SYNC_DLY_90_CYC 3'h4
`define SYNC_DLY_0_CYC 3'h5
`define OUT_DELAY_CYC 3'h2
// ----------------------------------------
// demux output clock: one period every four sample clocks
// ----------------------------------------
`define PHASE_W 2
`define PHASE_LAST 2'h3
`define ADJ_W 2
// ----------------------------------------
// control register location of the phase-select bits
// ----------------------------------------
`define PHASE_SEL_REG 4'hE
`define PHASE_SEL_LO_BIT 3
`define PHASE_SEL_HI_BIT 4
`endif

// File: verification/out_clock_sync_assertions.sv
`timescale 1ns/100ps
module out_clock_sync_assertions (
    input wire clk_in, input wire rst_n_in,
    input wire extended_control_mode_in, input wire sync_reset_enable_in,
    input wire demux_mode_in, input wire sync_reset_active_out, input wire sync_done_out,
    input wire i_channel_output_clock_out, input wire q_channel_output_clock_out
);
    wire ck = i_channel_output_clock_out;
    wire act = sync_reset_active_out;
    wire dm = demux_mode_in;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_rel; $fell(act); endsequence
    property p_en; act |-> extended_control_mode_in && sync_reset_enable_in; endproperty
    a_en: assert property (p_en) else $error("sync reset while disabled");
    property p_iq; ck == q_channel_output_clock_out; endproperty
    a_iq: assert property (p_iq) else $error("i and q clocks differ");
    property p_hold; dm && act && $past(act) |-> ck; endproperty
    a_hold: assert property (p_hold) else $error("demux clock not held");
    property p_tog; !dm && !$past(dm) |-> ck != $past(ck); endproperty
    a_tog: assert property (p_tog) else $error("clock stopped");
    // release to done is bounded; a wider window would hide a stuck delay count
    property p_rel; s_rel |-> ##[4:9] sync_done_out; endproperty
    a_rel: assert property (p_rel) else $error("no done after release");
    property p_wait; s_rel ##0 dm |-> ck [*3]; endproperty
    a_wait: assert property (p_wait) else $error("clock resumed early");
    property p_done; sync_done_out |=> !sync_done_out; endproperty
    a_done: assert property (p_done) else $error("done too long");
    property p_quiet; sync_done_out |-> !act; endproperty
    a_quiet: assert property (p_quiet) else $error("done during hold");
endmodule
bind out_clock_sync out_clock_sync_assertions i_out_clock_sync_assertions (.*);

// File: verification/ref_master.sv
`timescale 1ns/100ps
module ref_master (
    input wire clk_in,
    input wire rst_n_in,
    output wire ref_out
);
    reg [1:0] ph_r;
    // master demux clock phase: one of four sample clocks
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            ph_r <= 2'h0;
        else
            ph_r <= ph_r + 2'h1;
    end
    assign ref_out = (ph_r == 2'h0);
endmodule

// File: verification/test_out_clock_sync.sv
`timescale 1ns/100ps
`include "out_clock_sync_regs.vh"
module test_out_clock_sync;
    reg clk_in, rst_n_in, extended_control_mode_in, sync_reset_enable_in, demux_mode_in;
    reg output_clock_phase_select_in, slave_mode_in, out_clock_sync_reset_in;
    reg [1:0] aperture_delay_adjust_in;
    reg [31:0] rng = 32'h9144;
    integer fail_count = 0, n_compared = 0, n, d90, d0;
    wire i_channel_output_clock_out, q_channel_output_clock_out, sync_ref_clock_in;
    wire sync_ref_clock_out_a_out, sync_ref_clock_out_b_out, sync_reset_active_out, sync_done_out;
    out_clock_sync i_out_clock_sync (.*);
    ref_master i_ref_master (.clk_in(clk_in), .rst_n_in(rst_n_in), .ref_out(sync_ref_clock_in));
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    task chk(input string nm, input [7:0] e, input [7:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("ERROR %s expected %0d seen %0d", nm, e, g);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("compared %0d mismatches %0d", n_compared, fail_count);
            if (fail_count == 0 && n_compared > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // random hold length: release lands on any phase of the output clock
    task pulse(output integer c);
        begin
            rng = xs(rng);
            out_clock_sync_reset_in = 1;
            repeat (4 + rng[1:0]) @(negedge clk_in);
            if (demux_mode_in) chk("held", 1, i_channel_output_clock_out);
            out_clock_sync_reset_in = 0;
            for (c = 0; c < 40 && sync_done_out !== 1'b1; c = c + 1) @(negedge clk_in);
            if (c == 40) begin
                fail_count = fail_count + 1;
                tally_and_finish;
            end
            repeat (3) @(negedge clk_in);
            chk("aligned ref", 1, sync_ref_clock_out_a_out);
        end
    endtask
    initial begin
        clk_in = 0;
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        {rst_n_in, extended_control_mode_in, sync_reset_enable_in, slave_mode_in} = 4'h0;
        {demux_mode_in, output_clock_phase_select_in, out_clock_sync_reset_in} = 3'h4;
        aperture_delay_adjust_in = 2'h0;
        repeat (8) @(negedge clk_in);
        rst_n_in = 1;
        for (n = 0; n < 4; n = n + 1) begin
            {extended_control_mode_in, sync_reset_enable_in} = n[1:0];
            out_clock_sync_reset_in = 1;
            repeat (3) @(negedge clk_in);
            chk("active", n == 3, sync_reset_active_out);
            out_clock_sync_reset_in = 0;
            repeat (12) @(negedge clk_in);
        end
        $display("enables end");
        output_clock_phase_select_in = 1;
        pulse(d90); // dummy pulse
        pulse(d90);
        output_clock_phase_select_in = 0;
        pulse(d0);
        chk("delay", `SYNC_DLY_0_CYC - `SYNC_DLY_90_CYC, d0 - d90);
        demux_mode_in = 0;
        pulse(d0); // non-demux keeps toggling
        $display("sync delay end");
        {slave_mode_in, demux_mode_in, aperture_delay_adjust_in} = {2'h3, rng[3:2]};
        repeat (20) @(negedge clk_in);
        for (n = 0; n < 8 && sync_ref_clock_out_a_out !== 1'b1; n = n + 1) @(negedge clk_in);
        if (n == 8) begin
            fail_count = fail_count + 1;
            tally_and_finish;
        end
        @(negedge clk_in);
        chk("follow", 1, sync_ref_clock_in);
        repeat (3) @(negedge clk_in);
        chk("ref period", 1, sync_ref_clock_out_a_out);
        chk("ref pair", 1, sync_ref_clock_out_b_out);
        $display("slave end");
        tally_and_finish;
    end
endmodule
